// file: rtl/vpic_top.sv
// vectored priority interrupt controller with axi4-lite registers
//
// What this block does
// - request k uses vector k+8 at table word 0x14+2k, or 0x114+2k
// - reserved request numbers have no source and are never requested
// - trap vectors 0-7 start at word 0x4 or 0x104, fixed sources
// - thirty-three registers: two control, five flag, five enable, 18 prio, latch, status, core
// - peripherals or pins set pending flags; only software clears them
// - a source with its enable bit clear never requests the core
// - each user source has a 3-bit software priority, levels 0-7
// - flag, enable and priority positions follow request number order
// - latch register holds winner's 7-bit vector and 4-bit new level
// - cpu level is core-control bit 3 over status bits 7:5
// - status level bits are writable unless nesting disable is set
// - cpu level bit 3 is clear-only to software, set when a trap is taken
// - with level bit 3 set, level exceeds 7 and user sources block
// - status level 111 with bit 3 clear is level 7, users blocked
// - control one: nesting disable bit 15, trap flags bits 6..1
// - control two: external pin polarity and vector table select
// - alternate select makes every vector come from alternate table
// - at equal priority the lower vector address wins
// - each vector entry is a 24-bit routine start address
`timescale 1ns/1ps
module vpic_top #(
  parameter int SRC_COUNT = 72
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [vpic_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [vpic_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [vpic_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [vpic_pkg::DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic [SRC_COUNT-1:0]        src_event,
  input  wire logic [vpic_pkg::EXT_COUNT-1:0] ext_pin,
  input  wire logic [vpic_pkg::TRAP_COUNT-1:0] trap_event,
  input  wire logic                        core_ack,
  output logic                             irq_req_q,
  output logic [vpic_pkg::VEC_W-1:0]       irq_vector_q,
  output logic [vpic_pkg::LVL_W-1:0]       irq_level_q,
  output logic [23:0]                      irq_addr_q
);

  if (SRC_COUNT < 1 || SRC_COUNT > vpic_pkg::SRC_MAX)
  begin : g_bad_count
    $error("SRC_COUNT out of range");
  end

  localparam int NB = vpic_pkg::FLAG_BITS;
  localparam int RW = vpic_pkg::REG_W;

  // word index of an address, or the none code when unmapped
  function automatic logic [vpic_pkg::IDX_W-1:0] reg_index(
    input logic [vpic_pkg::ADDR_W-1:0] a
  );
    logic [vpic_pkg::ADDR_W-3:0] w;
    w = a[vpic_pkg::ADDR_W-1:2];
    if (w <= (vpic_pkg::ADDR_W-2)'(vpic_pkg::IDX_CORE))
      reg_index = vpic_pkg::IDX_W'(w);
    else
      reg_index = vpic_pkg::IDX_W'(vpic_pkg::IDX_NONE);
  endfunction

  function automatic logic [RW-1:0] merge(
    input logic [RW-1:0] old_v,
    input logic [RW-1:0] new_v,
    input logic [1:0]    strb
  );
    logic [RW-1:0] m;
    m = {{8{strb[1]}}, {8{strb[0]}}};
    merge = (old_v & ~m) | (new_v & m);
  endfunction

  // axi state
  logic                        aw_hold_q;
  logic [vpic_pkg::ADDR_W-1:0] aw_addr_q;
  logic                        w_hold_q;
  logic [RW-1:0]               wdata_q;
  logic [1:0]                  wstrb_q;
  logic                        wr_fire;
  logic [vpic_pkg::IDX_W-1:0]  wr_idx;
  logic [vpic_pkg::IDX_W-1:0]  rd_idx;
  logic [RW-1:0]               rd_word;

  // controller state
  logic [NB-1:0]               flag_q;
  logic [NB-1:0]               flag_d;
  logic [NB-1:0]               flag_set;
  logic [NB-1:0]               en_q;
  logic [NB-1:0]               en_d;
  logic [vpic_pkg::PRIO_W-1:0] prio_q [vpic_pkg::SRC_MAX];
  logic                        nest_q;
  logic [vpic_pkg::TRAP_COUNT-1:0] trap_q;
  logic [vpic_pkg::TRAP_COUNT-1:0] trap_d;
  logic                        alt_q;
  logic [vpic_pkg::EXT_COUNT-1:0] ext_pol_q;
  logic [vpic_pkg::EXT_COUNT-1:0] ext_s1_q;
  logic [vpic_pkg::EXT_COUNT-1:0] ext_s2_q;
  logic [vpic_pkg::EXT_COUNT-1:0] ext_s3_q;
  logic [vpic_pkg::EXT_COUNT-1:0] ext_edge;
  logic [vpic_pkg::PRIO_W-1:0] ipl_q;
  logic                        cpu_level_high_bit_q;
  logic [vpic_pkg::LVL_W-1:0]  cpu_level;
  logic [vpic_pkg::VEC_W-1:0]  latch_vec_q;
  logic [vpic_pkg::LVL_W-1:0]  latch_lvl_q;
  logic                        win_hit;
  logic [vpic_pkg::VEC_W-1:0]  win_vec;
  logic [vpic_pkg::LVL_W-1:0]  win_lvl;
  logic                        trap_hit;
  logic [vpic_pkg::VEC_W-1:0]  trap_vec;
  logic                        user_hit;
  logic [vpic_pkg::VEC_W-1:0]  user_vec;
  logic [vpic_pkg::LVL_W-1:0]  user_lvl;
  logic [RW-1:0]               wr_word;
  logic [RW-1:0]               ctl1_word;

  assign wr_fire = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wr_idx  = reg_index(aw_addr_q);
  assign rd_idx  = reg_index(s_axi_araddr);
  assign cpu_level = {cpu_level_high_bit_q, ipl_q};

  // write channel: address and data are taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q     <= 1'b0;
      aw_addr_q     <= '0;
      s_axi_awready <= 1'b1;
      w_hold_q      <= 1'b0;
      wdata_q       <= '0;
      wstrb_q       <= '0;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= vpic_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q     <= 1'b1;
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata[RW-1:0];
        wstrb_q      <= s_axi_wstrb[1:0];
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_idx == vpic_pkg::IDX_W'(vpic_pkg::IDX_NONE)) ?
                        vpic_pkg::RESP_DECERR : vpic_pkg::RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel answers on the same edge that takes the address
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= vpic_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {{(vpic_pkg::DATA_W-RW){1'b0}}, rd_word};
      s_axi_rresp   <= (rd_idx == vpic_pkg::IDX_W'(vpic_pkg::IDX_NONE)) ?
                       vpic_pkg::RESP_DECERR : vpic_pkg::RESP_OKAY;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // register read mux; unimplemented bits read zero
  always_comb
  begin
    int k;
    k = int'(rd_idx);
    rd_word = '0;
    if (k == vpic_pkg::IDX_CTL1)
    begin
      rd_word[vpic_pkg::CTL1_NEST_BIT] = nest_q;
      rd_word[vpic_pkg::CTL1_TRAP_LSB +: vpic_pkg::TRAP_COUNT] = trap_q;
    end
    else if (k == vpic_pkg::IDX_CTL2)
    begin
      rd_word[vpic_pkg::CTL2_ALT_BIT] = alt_q;
      rd_word[vpic_pkg::EXT_COUNT-1:0] = ext_pol_q;
    end
    else if (k >= vpic_pkg::IDX_FLAG0 && k < vpic_pkg::IDX_EN0)
      rd_word = flag_q[RW*(k-vpic_pkg::IDX_FLAG0) +: RW];
    else if (k >= vpic_pkg::IDX_EN0 && k < vpic_pkg::IDX_PRIO0)
      rd_word = en_q[RW*(k-vpic_pkg::IDX_EN0) +: RW];
    else if (k >= vpic_pkg::IDX_PRIO0 && k < vpic_pkg::IDX_LATCH)
    begin
      for (int j = 0; j < vpic_pkg::PRIO_PER_REG; j++)
        rd_word[vpic_pkg::PRIO_SLOT*j +: vpic_pkg::PRIO_W] =
          prio_q[vpic_pkg::PRIO_PER_REG*(k-vpic_pkg::IDX_PRIO0) + j];
    end
    else if (k == vpic_pkg::IDX_LATCH)
    begin
      rd_word[vpic_pkg::VEC_W-1:0] = latch_vec_q;
      rd_word[vpic_pkg::LATCH_LVL_LSB +: vpic_pkg::LVL_W] = latch_lvl_q;
    end
    else if (k == vpic_pkg::IDX_STATUS)
      rd_word[vpic_pkg::SR_IPL_LSB +: vpic_pkg::PRIO_W] = ipl_q;
    else if (k == vpic_pkg::IDX_CORE)
      rd_word[vpic_pkg::CORE_CPU_LEVEL_HIGH_BIT_BIT] = cpu_level_high_bit_q;
  end

  // external pins: two-stage synchroniser, then a third stage for edges
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ext_s1_q <= '0;
      ext_s2_q <= '0;
      ext_s3_q <= '0;
    end
    else
    begin
      ext_s1_q <= ext_pin;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  // polarity one selects the falling edge
  assign ext_edge = (ext_pol_q & ext_s3_q & ~ext_s2_q) |
                    (~ext_pol_q & ext_s2_q & ~ext_s3_q);

  always_comb
  begin
    flag_set = '0;
    for (int i = 0; i < SRC_COUNT; i++)
      flag_set[i] = src_event[i];
    for (int e = 0; e < vpic_pkg::EXT_COUNT; e++)
      flag_set[vpic_pkg::EXT_IRQ[e]] = flag_set[vpic_pkg::EXT_IRQ[e]] |
                                       ext_edge[e];
  end

  // pending flags: a hardware set in the clearing cycle wins
  always_comb
  begin
    flag_d = flag_q;
    en_d   = en_q;
    wr_word = merge('0, wdata_q, wstrb_q);
    for (int f = 0; f < vpic_pkg::FLAG_REGS; f++)
    begin
      if (wr_fire && wr_idx == vpic_pkg::IDX_W'(vpic_pkg::IDX_FLAG0 + f))
        flag_d[RW*f +: RW] = merge(flag_q[RW*f +: RW], wdata_q, wstrb_q);
      if (wr_fire && wr_idx == vpic_pkg::IDX_W'(vpic_pkg::IDX_EN0 + f))
        en_d[RW*f +: RW] = merge(en_q[RW*f +: RW], wdata_q, wstrb_q);
    end
    flag_d = (flag_d | flag_set) & vpic_pkg::IMPL_MASK;
    en_d   = en_d & vpic_pkg::IMPL_MASK;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_q <= '0;
      en_q   <= '0;
    end
    else
    begin
      flag_q <= flag_d;
      en_q   <= en_d;
    end
  end

  // priority fields, four 3-bit fields in 4-bit slots per register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < vpic_pkg::SRC_MAX; i++)
        prio_q[i] <= '0;
    end
    else
    begin
      for (int p = 0; p < vpic_pkg::PRIO_REGS; p++)
        if (wr_fire && wr_idx == vpic_pkg::IDX_W'(vpic_pkg::IDX_PRIO0 + p))
          for (int j = 0; j < vpic_pkg::PRIO_PER_REG; j++)
            prio_q[vpic_pkg::PRIO_PER_REG*p + j] <=
              wr_word[vpic_pkg::PRIO_SLOT*j +: vpic_pkg::PRIO_W];
    end
  end

  // control one: trap flags stay set until software writes zero
  assign ctl1_word = merge({nest_q,
                            {(RW-vpic_pkg::TRAP_COUNT-2){1'b0}},
                            trap_q, 1'b0}, wdata_q, wstrb_q);

  always_comb
  begin
    trap_d = trap_q;
    if (wr_fire && wr_idx == vpic_pkg::IDX_W'(vpic_pkg::IDX_CTL1))
      trap_d = ctl1_word[vpic_pkg::CTL1_TRAP_LSB +: vpic_pkg::TRAP_COUNT];
    trap_d = trap_d | trap_event;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nest_q    <= 1'b0;
      trap_q    <= '0;
      alt_q     <= 1'b0;
      ext_pol_q <= '0;
    end
    else
    begin
      trap_q <= trap_d;
      if (wr_fire && wr_idx == vpic_pkg::IDX_W'(vpic_pkg::IDX_CTL1))
        nest_q <= ctl1_word[vpic_pkg::CTL1_NEST_BIT];
      if (wr_fire && wr_idx == vpic_pkg::IDX_W'(vpic_pkg::IDX_CTL2))
      begin
        alt_q     <= wr_word[vpic_pkg::CTL2_ALT_BIT] |
                     (alt_q & ~wstrb_q[1]);
        ext_pol_q <= wstrb_q[0] ? wr_word[vpic_pkg::EXT_COUNT-1:0] :
                     ext_pol_q;
      end
    end
  end

  // cpu level: taking a request loads its level, beating software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ipl_q <= '0;
    else if (core_ack && irq_req_q)
      ipl_q <= irq_level_q[vpic_pkg::PRIO_W-1:0];
    else if (wr_fire && !nest_q && wstrb_q[0] &&
             wr_idx == vpic_pkg::IDX_W'(vpic_pkg::IDX_STATUS))
      ipl_q <= wdata_q[vpic_pkg::SR_IPL_LSB +: vpic_pkg::PRIO_W];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cpu_level_high_bit_q <= 1'b0;
    else if (core_ack && irq_req_q)
      cpu_level_high_bit_q <= irq_level_q[vpic_pkg::LVL_W-1];
    else if (wr_fire && wstrb_q[0] && !wdata_q[vpic_pkg::CORE_CPU_LEVEL_HIGH_BIT_BIT] &&
             wr_idx == vpic_pkg::IDX_W'(vpic_pkg::IDX_CORE))
      cpu_level_high_bit_q <= 1'b0;
  end

  // arbitration; strict compare keeps the lowest vector on a tie
  always_comb
  begin
    trap_hit = 1'b0;
    trap_vec = '0;
    for (int t = 0; t < vpic_pkg::TRAP_COUNT; t++)
      if (trap_q[t] && (!trap_hit || vpic_pkg::TRAP_VEC[t] < trap_vec))
      begin
        trap_hit = 1'b1;
        trap_vec = vpic_pkg::TRAP_VEC[t];
      end
    user_hit = 1'b0;
    user_vec = '0;
    user_lvl = cpu_level;
    for (int i = 0; i < vpic_pkg::SRC_MAX; i++)
      if (flag_q[i] && en_q[i] && {1'b0, prio_q[i]} > user_lvl)
      begin
        user_hit = 1'b1;
        user_lvl = {1'b0, prio_q[i]};
        user_vec = irq_vec_of(i);
      end
    win_hit = user_hit;
    win_vec = user_vec;
    win_lvl = user_lvl;
    if (trap_hit &&
        vpic_pkg::TRAP_LVL_TOP - vpic_pkg::LVL_W'(trap_vec) > cpu_level)
    begin
      win_hit = 1'b1;
      win_vec = trap_vec;
      win_lvl = vpic_pkg::TRAP_LVL_TOP - vpic_pkg::LVL_W'(trap_vec);
    end
  end

  function automatic logic [vpic_pkg::VEC_W-1:0] irq_vec_of(input int i);
    irq_vec_of = vpic_pkg::VEC_W'(i) + vpic_pkg::IRQ_VEC_OFS;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_req_q    <= 1'b0;
      irq_vector_q <= '0;
      irq_level_q  <= '0;
      irq_addr_q   <= '0;
      latch_vec_q  <= '0;
      latch_lvl_q  <= '0;
    end
    else
    begin
      irq_req_q    <= win_hit;
      irq_vector_q <= win_vec;
      irq_level_q  <= win_lvl;
      irq_addr_q   <= (alt_q ? vpic_pkg::ALT_TRAP_BASE :
                       vpic_pkg::PRI_TRAP_BASE) +
                      {16'h0, win_vec, 1'b0};
      if (win_hit)
      begin
        latch_vec_q <= win_vec;
        latch_lvl_q <= win_lvl;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reserved_flags_a: assert property ((flag_q & ~vpic_pkg::IMPL_MASK) == '0)
    else $error("reserved flag set");
  user_enabled_a: assert property (irq_req_q &&
      irq_vector_q >= vpic_pkg::IRQ_VEC_OFS |->
      $past(en_q[win_vec - vpic_pkg::IRQ_VEC_OFS]))
    else $error("disabled source requested");
  above_level_a: assert property (irq_req_q |->
      irq_level_q > $past(cpu_level))
    else $error("request not above cpu level");
  high_bit_block_a: assert property (cpu_level_high_bit_q ##1 cpu_level_high_bit_q |->
      !(irq_req_q && irq_vector_q >= vpic_pkg::IRQ_VEC_OFS))
    else $error("user request while level above 7");
  flag_sticky_a: assert property (!$past(wr_fire) |->
      (($past(flag_q) & ~flag_q) == '0))
    else $error("flag cleared without write");
  trap_sticky_a: assert property ($past(trap_event) != '0 |->
      ($past(trap_event) & ~trap_q) == '0)
    else $error("trap event lost");
  irq_addr_a: assert property (irq_req_q &&
      irq_vector_q >= vpic_pkg::IRQ_VEC_OFS |->
      irq_addr_q == ($past(alt_q) ? vpic_pkg::ALT_IRQ_BASE :
      vpic_pkg::PRI_IRQ_BASE) +
      {16'h0, irq_vector_q - vpic_pkg::IRQ_VEC_OFS, 1'b0})
    else $error("wrong vector address");
  nest_lock_a: assert property (nest_q && !(core_ack && irq_req_q) |=>
      ipl_q == $past(ipl_q))
    else $error("level changed while nesting disabled");
  no_raise_a: assert property (!cpu_level_high_bit_q && !(core_ack && irq_req_q) |=>
      !cpu_level_high_bit_q)
    else $error("software raised level bit 3");
  latch_match_a: assert property (irq_req_q |->
      latch_vec_q == irq_vector_q && latch_lvl_q == irq_level_q)
    else $error("latch differs from request");

  user_irq_c: cover property (irq_req_q && irq_vector_q >= 7'h08 ##1 core_ack);
  trap_c: cover property (irq_req_q && irq_vector_q < 7'h08);
  alt_c: cover property (alt_q && irq_req_q);
  write_read_c: cover property (wr_fire ##[1:8] s_axi_rvalid);

endmodule

// file: rtl/vpic_pkg.sv
// constants shared by the vectored priority interrupt controller
package vpic_pkg;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;
  localparam int REG_W     = 16;
  localparam int IDX_W     = 6;
  // word indices; byte address is four times the index
  localparam int IDX_CTL1   = 0;
  localparam int IDX_CTL2   = 1;
  localparam int IDX_FLAG0  = 2;
  localparam int IDX_EN0    = 7;
  localparam int IDX_PRIO0  = 12;
  localparam int IDX_LATCH  = 30;
  localparam int IDX_STATUS = 31;
  localparam int IDX_CORE   = 32;
  localparam int IDX_NONE   = 63;
  localparam int FLAG_REGS  = 5;
  localparam int PRIO_REGS  = 18;
  localparam int PRIO_PER_REG = 4;
  localparam int PRIO_SLOT  = 4;
  localparam int PRIO_W     = 3;
  localparam int LVL_W      = 4;
  localparam int VEC_W      = 7;
  localparam int SRC_MAX    = 72;
  localparam int FLAG_BITS  = 80;
  // sources with a request line attached; all others are reserved
  localparam logic [FLAG_BITS-1:0] IMPL_MASK =
    80'h00f6_21ff_dfff_fffb_7fff;
  // vector table word addresses
  localparam logic [23:0] PRI_TRAP_BASE = 24'h000004;
  localparam logic [23:0] ALT_TRAP_BASE = 24'h000104;
  localparam logic [23:0] PRI_IRQ_BASE  = 24'h000014;
  localparam logic [23:0] ALT_IRQ_BASE  = 24'h000114;
  localparam logic [VEC_W-1:0] IRQ_VEC_OFS = 7'h08;
  // register fields
  localparam int CTL1_NEST_BIT  = 15;
  localparam int CTL1_TRAP_LSB  = 1;
  localparam int TRAP_COUNT     = 6;
  localparam int CTL2_ALT_BIT   = 15;
  localparam int EXT_COUNT      = 5;
  localparam int SR_IPL_LSB     = 5;
  localparam int CORE_CPU_LEVEL_HIGH_BIT_BIT  = 3;
  localparam int LATCH_LVL_LSB  = 8;
  // trap flag order: osc, stack, address, math, dma, divide-by-zero
  localparam logic [VEC_W-1:0] TRAP_VEC [TRAP_COUNT] =
    '{7'h01, 7'h03, 7'h02, 7'h04, 7'h05, 7'h04};
  localparam logic [LVL_W-1:0] TRAP_LVL_TOP = 4'hf;
  // request numbers of the external pins
  localparam int EXT_IRQ [EXT_COUNT] = '{0, 20, 29, 53, 54};
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// file: verification/vpic_core_model.sv
// core side model: takes a pending request after a set wait
`timescale 1ns/1ps
module vpic_core_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       irq_req_q,
  input  wire logic       ack_en,
  input  wire logic [3:0] wait_cycles,
  output logic            core_ack
);
  logic [3:0] cnt_q;
  // one pulse per request; the level load then drops the request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q    <= 4'h0;
      core_ack <= 1'b0;
    end
    else
    begin
      core_ack <= 1'b0;
      cnt_q    <= 4'h0;
      if (ack_en && irq_req_q && !core_ack)
      begin
        if (cnt_q == wait_cycles)
          core_ack <= 1'b1;
        else
          cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule

// file: verification/vpic_top_tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module vpic_top_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [71:0] src_event = 72'h0;
  logic [4:0]  ext_pin = 5'h0;
  logic [5:0]  trap_event = 6'h0;
  logic        ack_en = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, core_ack;
  logic        irq_req_q;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [6:0]  irq_vector_q;
  logic [3:0]  irq_level_q;
  logic [23:0] irq_addr_q;
  int          n_fail = 0;
  int          comparisons = 0;

  always #2.5 aclk = ~aclk;

  vpic_top vpic_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .src_event(src_event), .ext_pin(ext_pin),
    .trap_event(trap_event), .core_ack(core_ack),
    .irq_req_q(irq_req_q), .irq_vector_q(irq_vector_q),
    .irq_level_q(irq_level_q), .irq_addr_q(irq_addr_q));

  vpic_core_model vpic_core_model_i (.aclk(aclk), .aresetn(aresetn),
    .irq_req_q(irq_req_q), .ack_en(ack_en), .wait_cycles(4'h2),
    .core_ack(core_ack));

  task automatic wrap_up();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    n_fail++;
    wrap_up();
  endtask

  task automatic wr(input int idx, input logic [15:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= 12'(idx * 4);
    wdata   <= {16'h0, v};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bready && bvalid) && n < 50);
    if (n >= 50) hang();
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input int idx);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= 12'(idx * 4);
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rready && rvalid) && n < 50);
    if (n >= 50) hang();
    r = rresp;
    d = rdata;
    rready <= 1'b0;
  endtask

  // request outputs settle two edges after an input event
  task automatic irq(input logic v, input logic [6:0] vec,
                     input logic [3:0] lv, input logic [23:0] a);
    repeat (3) @(posedge aclk);
    chk(irq_req_q, v);
    if (v)
    begin
      chk(irq_vector_q, vec);
      chk(irq_level_q, lv);
      chk(irq_addr_q, a);
    end
  endtask

  task automatic pulse(input int k);
    @(posedge aclk);
    src_event[k] <= 1'b1;
    @(posedge aclk);
    src_event[k] <= 1'b0;
  endtask

  task automatic s_reset();
    rd(vpic_pkg::IDX_CTL1);
    chk(r, vpic_pkg::RESP_OKAY);
    chk(d, 32'h0);
    rd(vpic_pkg::IDX_NONE);
    chk(r, vpic_pkg::RESP_DECERR);
    chk(d, 32'h0);
    wr(vpic_pkg::IDX_NONE, 16'hffff);
    chk(r, vpic_pkg::RESP_DECERR);
  endtask

  task automatic s_user();
    wr(vpic_pkg::IDX_EN0, 16'h000a);
    wr(vpic_pkg::IDX_PRIO0, 16'h5050);
    pulse(3);
    irq(1'b1, 7'd11, 4'h5, 24'h00001a);
    pulse(1);
    irq(1'b1, 7'd9, 4'h5, 24'h000016);
    rd(vpic_pkg::IDX_LATCH);
    chk(d, 32'h0509);
    ack_en <= 1'b1;
    // the core waits before taking, and the request drops two edges later
    repeat (4) @(posedge aclk);
    irq(1'b0, 7'h0, 4'h0, 24'h0);
    ack_en <= 1'b0;
    rd(vpic_pkg::IDX_STATUS);
    chk(d, 32'h00a0);
  endtask

  task automatic s_level();
    wr(vpic_pkg::IDX_STATUS, 16'h0080);
    irq(1'b1, 7'd9, 4'h5, 24'h000016);
    wr(vpic_pkg::IDX_CTL2, 16'h8000);
    irq(1'b1, 7'd9, 4'h5, 24'h000116);
    wr(vpic_pkg::IDX_CTL2, 16'h0000);
    wr(vpic_pkg::IDX_STATUS, 16'h00e0);
    irq(1'b0, 7'h0, 4'h0, 24'h0);
    wr(vpic_pkg::IDX_CTL1, 16'h8000);
    wr(vpic_pkg::IDX_STATUS, 16'h0000);
    rd(vpic_pkg::IDX_STATUS);
    chk(d, 32'h00e0);
    wr(vpic_pkg::IDX_CTL1, 16'h0000);
    wr(vpic_pkg::IDX_STATUS, 16'h0000);
    wr(vpic_pkg::IDX_CORE, 16'h0008);
    rd(vpic_pkg::IDX_CORE);
    chk(d, 32'h0);
    wr(vpic_pkg::IDX_EN0, 16'h0000);
    irq(1'b0, 7'h0, 4'h0, 24'h0);
  endtask

  task automatic s_trap();
    @(posedge aclk);
    trap_event[2] <= 1'b1;
    @(posedge aclk);
    trap_event[2] <= 1'b0;
    irq(1'b1, 7'd2, 4'hd, 24'h000008);
    rd(vpic_pkg::IDX_CTL1);
    chk(d, 32'h0008);
    ack_en <= 1'b1;
    repeat (4) @(posedge aclk);
    irq(1'b0, 7'h0, 4'h0, 24'h0);
    ack_en <= 1'b0;
    rd(vpic_pkg::IDX_CORE);
    chk(d, 32'h0008);
    wr(vpic_pkg::IDX_CTL1, 16'h0000);
    wr(vpic_pkg::IDX_FLAG0, 16'h0000);
    pulse(15);
    ext_pin[0] <= 1'b1;
    repeat (8) @(posedge aclk);
    rd(vpic_pkg::IDX_FLAG0);
    chk(d, 32'h0001);
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    s_reset();
    s_user();
    s_level();
    s_trap();
    wrap_up();
  end
endmodule
